// ==== design/i2c_status_mask.sv ====
module i2c_status_mask
  import i2c_stat_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire link_ev_t link_ev,
  input wire logic link_ev_valid,
  output logic link_ev_ready,
  input wire logic link_busy,
  output logic link_tx_pending,
  output logic [7:0] link_tx_byte,
  output logic rx_done_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Link side: events are held and announced with a toggle.

  link_ev_t ev_hold_q; // Event held stable while pclk picks it up.
  logic req_tg_q; // Toggles once per event, link domain.
  logic ack_s1_q; // First stage of the returning acknowledge.
  logic ack_s2_q; // Synchronised acknowledge toggle.
  logic tbf_l1_q; // First stage of the transmit-full level.
  logic tbf_l2_q; // Transmit-full level in the link domain.
  logic ack_tg_q; // Acknowledge toggle returned to the link side, pclk domain.
  logic tbf_q; // Transmit-full flag, pclk domain, read here by the synchroniser.

  // Ready while no event is outstanding; a new event would corrupt the hold.
  assign link_ev_ready = (ack_s2_q == req_tg_q);
  assign link_tx_pending = tbf_l2_q;

  // Capture an accepted event and flip the request toggle.
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      ev_hold_q <= '0;
      req_tg_q <= 1'b0;
    end else if (link_ev_valid && link_ev_ready) begin
      ev_hold_q <= link_ev;
      req_tg_q <= ~req_tg_q;
    end
  end

  // Bring the acknowledge toggle and the transmit-full level over.
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      tbf_l1_q <= 1'b0;
      tbf_l2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tg_q;
      ack_s2_q <= ack_s1_q;
      tbf_l1_q <= tbf_q;
      tbf_l2_q <= tbf_l1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into pclk.

  logic req_s1_q; // First stage, read only by the second.
  logic req_s2_q; // Synchronised request toggle.
  logic req_s3_q; // Previous value for edge detection.
  logic busy_s1_q; // First stage of the busy level.
  logic busy_s2_q; // Synchronised busy level.
  logic ev_fire; // One-cycle pulse: the held event is now valid here.
  link_ev_t ev; // Event payload, stable while the toggles differ.

  assign ev_fire = req_s2_q ^ req_s3_q;
  assign ev = ev_hold_q;

  // Two flip-flops per crossing; the edge detector reads the second and its delayed copy, never the first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_tg_q <= 1'b0;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_tg_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      ack_tg_q <= req_s2_q;
      busy_s1_q <= link_busy;
      busy_s2_q <= busy_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decode and address compare.

  logic is_start, is_stop, is_mtx, is_ack, is_coll, is_addr, is_data, is_txd;
  logic [9:0] mask_q; // Address bits to leave out of the compare.
  logic [1:0] ctrl_q; // Width select and general call enable.
  logic [9:0] own_addr_q; // Own slave address.
  addr_stage_t stage_q; // Which address byte is expected next.
  logic slave_q; // Addressed as slave in the current transfer.
  logic ten_mode; // Ten-bit addressing selected.
  logic cmp7, cmp10_hi, cmp10_lo, gc_hit;
  logic first_hit; // First address byte accepted.
  logic addr_match; // Full device address matched.

  assign is_start = ev_fire && (ev.kind == EV_START);
  assign is_stop = ev_fire && (ev.kind == EV_STOP);
  assign is_mtx = ev_fire && (ev.kind == EV_MTX_BEGIN);
  assign is_ack = ev_fire && (ev.kind == EV_ACK_SLOT);
  assign is_coll = ev_fire && (ev.kind == EV_COLLISION);
  assign is_addr = ev_fire && (ev.kind == EV_ADDR_BYTE);
  assign is_data = ev_fire && (ev.kind == EV_DATA_BYTE);
  assign is_txd = ev_fire && (ev.kind == EV_TX_DONE);

  assign ten_mode = ctrl_q[CTL_WIDTH_BIT];
  // Seven-bit compare looks at mask bits 6..0 only.
  assign cmp7 = (((ev.data[7:1] ^ own_addr_q[6:0]) & ~mask_q[6:0]) == 7'h00);
  assign cmp10_hi = (ev.data[7:3] == TEN_BIT_PREFIX)
                    && (((ev.data[2:1] ^ own_addr_q[9:8]) & ~mask_q[9:8]) == 2'h0);
  assign cmp10_lo = (((ev.data ^ own_addr_q[7:0]) & ~mask_q[7:0]) == 8'h00);
  assign gc_hit = is_addr && (stage_q == AS_FIRST) && (ev.data == GC_ADDR)
                  && ctrl_q[CTL_GCEN_BIT];
  assign first_hit = is_addr && (stage_q == AS_FIRST) && (ten_mode ? cmp10_hi : cmp7);
  assign addr_match = (first_hit && !ten_mode)
                      || (is_addr && (stage_q == AS_SECOND) && cmp10_lo);

  // Address stage: a start opens it, a stop closes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q <= AS_IDLE;
    end else if (is_stop) begin
      stage_q <= AS_IDLE;
    end else if (is_start) begin
      stage_q <= AS_FIRST;
    end else if (is_addr) begin
      case (stage_q)
        AS_FIRST: begin
          stage_q <= (ten_mode && cmp10_hi) ? AS_SECOND : AS_DONE;
        end
        AS_SECOND: begin
          stage_q <= AS_DONE;
        end
        default: begin
          stage_q <= stage_q;
        end
      endcase
    end
  end

  // Slave role holds from a match until the next start or stop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_q <= 1'b0;
    end else if (is_start || is_stop) begin
      slave_q <= 1'b0;
    end else if (addr_match || gc_hit) begin
      slave_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  logic acc, wr, rd, mapped;
  logic stat_wr, mask_wr, ctrl_wr, own_wr, tx_wr, rx_rd;
  logic [7:0] tx_q; // Transmit holding register.
  logic [7:0] rx_q; // Receive holding register.
  logic [31:0] prdata_q; // Read data, loaded in the setup cycle.
  logic [15:0] status; // Assembled status word.

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign mapped = (paddr == OFF_STATUS) || (paddr == OFF_MASK) || (paddr == OFF_CTRL)
                  || (paddr == OFF_OWN_ADDR) || (paddr == OFF_TX) || (paddr == OFF_RX);
  assign stat_wr = wr && (paddr == OFF_STATUS);
  assign mask_wr = wr && (paddr == OFF_MASK);
  assign ctrl_wr = wr && (paddr == OFF_CTRL);
  assign own_wr = wr && (paddr == OFF_OWN_ADDR);
  assign tx_wr = wr && (paddr == OFF_TX);
  assign rx_rd = rd && (paddr == OFF_RX);
  // Zero wait states keep the access phase to a single cycle.
  assign pready = acc;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_q;

  // Read data is sampled at setup, so it is steady through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_STATUS: prdata_q <= {16'h0000, status};
        OFF_MASK: prdata_q <= {22'h000000, mask_q};
        OFF_CTRL: prdata_q <= {30'h00000000, ctrl_q};
        OFF_OWN_ADDR: prdata_q <= {22'h000000, own_addr_q};
        OFF_TX: prdata_q <= {24'h000000, tx_q};
        OFF_RX: prdata_q <= {24'h000000, rx_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Plain configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= MASK_RST[9:0];
      ctrl_q <= CTRL_RST;
      own_addr_q <= OWN_ADDR_RST;
    end else begin
      if (mask_wr) mask_q <= pwdata[9:0] & MASK_IMPL;
      if (ctrl_wr) ctrl_q <= pwdata[1:0];
      if (own_wr) own_addr_q <= pwdata[9:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set always wins over a software write.

  logic ack_q, trs_q, bcl_q, gc_q, a10_q, iwc_q, ov_q;
  logic da_q, p_q, s_q, rw_q, rbf_q;
  logic tx_accept, tx_reject, rx_xfer, rx_load, rx_ovf;

  assign tx_reject = tx_wr && (busy_s2_q || tbf_q);
  assign tx_accept = tx_wr && !tx_reject;
  assign rx_xfer = is_data || first_hit || gc_hit || addr_match;
  // A read in the same cycle frees the buffer for the new byte.
  assign rx_load = rx_xfer && (!rbf_q || rx_rd);
  assign rx_ovf = rx_xfer && rbf_q && !rx_rd;

  assign status = {ack_q, trs_q, 3'b000, bcl_q, gc_q, a10_q,
                   iwc_q, ov_q, da_q, p_q, s_q, rw_q, rbf_q, tbf_q};

  // Master transmit progress and acknowledge result.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= STATUS_RST[ACK_BIT];
      trs_q <= STATUS_RST[TRS_BIT];
    end else begin
      if (is_ack) ack_q <= ev.nack;
      else if (stat_wr) ack_q <= pwdata[ACK_BIT];
      if (is_mtx) trs_q <= 1'b1;
      else if (is_ack) trs_q <= 1'b0;
      else if (stat_wr) trs_q <= pwdata[TRS_BIT];
    end
  end

  // Sticky error flags; only software takes them down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcl_q <= STATUS_RST[BCL_BIT];
      iwc_q <= STATUS_RST[IWC_BIT];
      ov_q <= STATUS_RST[OV_BIT];
    end else begin
      if (is_coll) bcl_q <= 1'b1;
      else if (stat_wr) bcl_q <= pwdata[BCL_BIT];
      if (tx_reject) iwc_q <= 1'b1;
      else if (stat_wr) iwc_q <= pwdata[IWC_BIT];
      if (rx_ovf) ov_q <= 1'b1;
      else if (stat_wr) ov_q <= pwdata[OV_BIT];
    end
  end

  // Address flags, cleared by the stop that ends the transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc_q <= STATUS_RST[GC_BIT];
      a10_q <= STATUS_RST[A10_BIT];
    end else begin
      if (gc_hit) gc_q <= 1'b1;
      else if (is_stop) gc_q <= 1'b0;
      else if (stat_wr) gc_q <= pwdata[GC_BIT];
      if (addr_match && (stage_q == AS_SECOND)) a10_q <= 1'b1;
      else if (is_stop) a10_q <= 1'b0;
      else if (stat_wr) a10_q <= pwdata[A10_BIT];
    end
  end

  // Read-only slave and bus condition flags; writes never reach them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      da_q <= STATUS_RST[DA_BIT];
      p_q <= STATUS_RST[P_BIT];
      s_q <= STATUS_RST[S_BIT];
      rw_q <= STATUS_RST[RW_BIT];
    end else begin
      if (addr_match || gc_hit) da_q <= 1'b0;
      else if (is_data && slave_q) da_q <= 1'b1;
      if (is_start) begin
        s_q <= 1'b1;
        p_q <= 1'b0;
      end else if (is_stop) begin
        s_q <= 1'b0;
        p_q <= 1'b1;
      end
      if (first_hit || gc_hit) rw_q <= ev.data[0];
    end
  end

  // Buffers and their full flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbf_q <= STATUS_RST[RBF_BIT];
      tbf_q <= STATUS_RST[TBF_BIT];
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      rx_done_pulse <= 1'b0;
    end else begin
      rx_done_pulse <= rx_load;
      if (rx_load) begin
        rx_q <= ev.data;
        rbf_q <= 1'b1;
      end else if (rx_rd) begin
        rbf_q <= 1'b0;
      end
      if (tx_accept) begin
        tx_q <= pwdata[7:0];
        tbf_q <= 1'b1;
      end else if (is_txd) begin
        tbf_q <= 1'b0;
      end
    end
  end

  // Held steady while the link sees transmit-full, so it crosses safely.
  assign link_tx_byte = tx_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_mtx_begin;
    is_mtx && !is_ack;
  endsequence

  sequence s_ack_slot;
    is_ack;
  endsequence

  chk_ack_result: assert property (s_ack_slot |=> ack_q == $past(ev.nack))
    else $error("ack flag not updated at ack slot");
  chk_trs_begin: assert property (s_mtx_begin |=> trs_q)
    else $error("transmit status not set at begin");
  chk_trs_end: assert property (s_ack_slot |=> !trs_q)
    else $error("transmit status not cleared at ack");
  chk_bcl_sticky: assert property (bcl_q && !stat_wr |=> bcl_q)
    else $error("collision flag dropped without write");
  chk_gc_stop: assert property (is_stop && !stat_wr |=> !gc_q && !a10_q)
    else $error("address flags not cleared at stop");
  chk_a10_set: assert property (addr_match && stage_q == AS_SECOND |=> a10_q)
    else $error("ten-bit flag not set on match");
  chk_tx_write_collision_reject: assert property (tx_reject |=> iwc_q && tx_q == $past(tx_q))
    else $error("busy write not rejected");
  chk_ovf_keep: assert property (rx_ovf |=> ov_q && $stable(rx_q))
    else $error("overflow not flagged or buffer overwritten");
  chk_start_stop: assert property (is_start |=> s_q && !p_q)
    else $error("start not recorded");
  chk_rbf_read: assert property (rx_rd && !rx_xfer |=> !rbf_q)
    else $error("receive full not cleared by read");
  chk_rx_pulse: assert property (rx_load |=> rx_done_pulse && rbf_q ##1 !rx_done_pulse)
    else $error("receive pulse wrong");
  chk_rsv_zero: assert property (rd && paddr == OFF_STATUS |-> prdata[13:11] == 3'b000)
    else $error("reserved status bits not zero");
  chk_tbf_set: assert property (tx_accept |=> tbf_q [*2])
    else $error("transmit full not held after write");

endmodule

// ==== design/i2c_stat_pkg.sv ====
//  Contract
//  - Ack slot end records slave ack or nack
//  - Master transmit flag spans byte plus ack
//  - Bus collision sets sticky flag, software clears
//  - General call flag sets on match, stop clears
//  - Ten-bit flag sets on second byte match
//  - Transmit write while busy rejected, flag set
//  - New byte with full buffer sets overflow
//  - Address match clears, slave data sets data flag
//  - Start and stop flags show last condition
//  - Direction flag from slave address byte
//  - Receive full set on load, cleared on read
//  - Transmit full set on write, cleared when sent
//  - Mask bit one excludes address bit compare
//  - Unused status and mask bits read zero
//  - Completed byte moves to buffer with pulse
//  - Width select picks ten or seven bit address
//  - Low six status bits read-only, bits 15:14 and 10:6 writable
package i2c_stat_pkg;

  // Register offsets, byte addresses of aligned 32-bit words.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_OWN_ADDR = 8'h0C;
  localparam logic [7:0] OFF_TX = 8'h10;
  localparam logic [7:0] OFF_RX = 8'h14;

  // Status bit positions.
  localparam int ACK_BIT = 15;
  localparam int TRS_BIT = 14;
  localparam int BCL_BIT = 10;
  localparam int GC_BIT = 9;
  localparam int A10_BIT = 8;
  localparam int IWC_BIT = 7;
  localparam int OV_BIT = 6;
  localparam int DA_BIT = 5;
  localparam int P_BIT = 4;
  localparam int S_BIT = 3;
  localparam int RW_BIT = 2;
  localparam int RBF_BIT = 1;
  localparam int TBF_BIT = 0;

  // Control register bit positions.
  localparam int CTL_WIDTH_BIT = 0;
  localparam int CTL_GCEN_BIT = 1;

  // Reset values and implemented-bit masks.
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [9:0] MASK_IMPL = 10'h3FF;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [9:0] OWN_ADDR_RST = 10'h000;

  // Bus address constants.
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

  // Kinds of event reported by the bus engine on the link clock.
  typedef enum logic [3:0] {
    EV_NONE = 4'h0,
    EV_START = 4'h1,
    EV_STOP = 4'h2,
    EV_MTX_BEGIN = 4'h3,
    EV_ACK_SLOT = 4'h4,
    EV_COLLISION = 4'h5,
    EV_ADDR_BYTE = 4'h6,
    EV_DATA_BYTE = 4'h7,
    EV_TX_DONE = 4'h8
  } ev_kind_t;

  // One bus event with its payload.
  typedef struct packed {
    ev_kind_t kind;
    logic nack;
    logic [7:0] data;
  } link_ev_t;

  // Address phase tracking.
  typedef enum logic [1:0] {
    AS_IDLE = 2'b00,
    AS_FIRST = 2'b01,
    AS_SECOND = 2'b10,
    AS_DONE = 2'b11
  } addr_stage_t;

endpackage

// ==== testbench/i2c_bus_engine_model.sv ====
// Behavioural bus engine: offers one link event at a time on the link clock.
module i2c_bus_engine_model
  import i2c_stat_pkg::*;
(
  input wire logic link_clk,
  input wire logic link_ev_ready,
  output link_ev_t link_ev,
  output logic link_ev_valid,
  output logic link_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle state at time zero.
  initial begin
    link_ev = '0;
    link_ev_valid = 1'b0;
    link_busy = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offer one event, hold it until taken, then wait for the ready round trip.
  // Released payload shows the inverse of the last value, so nothing relies on it.
  // No local limit: a handshake that never completes is caught by the bench watchdog.
  task automatic send(input ev_kind_t k, input logic n, input logic [7:0] d);
    @(posedge link_clk);
    link_ev <= '{k, n, d};
    link_ev_valid <= 1'b1;
    link_busy <= 1'b1;
    do @(posedge link_clk); while (link_ev_ready !== 1'b1);
    link_ev_valid <= 1'b0;
    link_busy <= 1'b0;
    link_ev <= ~link_ev;
    while (link_ev_ready === 1'b1) @(posedge link_clk);
    while (link_ev_ready !== 1'b1) @(posedge link_clk);
  endtask
endmodule

// ==== testbench/i2c_status_and_address_mask_bench.sv ====
// Self-checking bench: APB register traffic plus link events from the engine model.
module i2c_status_and_address_mask_bench
  import i2c_stat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic link_clk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  link_ev_t link_ev;
  logic link_ev_valid;
  logic link_ev_ready;
  logic link_busy;
  logic link_tx_pending;
  logic [7:0] link_tx_byte;
  logic rx_done_pulse;
  logic [32:0] expq[$]; // Expected {pslverr, prdata} of each read, oldest first.
  int mismatches = 0;
  int n_checks = 0;
  int pulses = 0;
  logic [31:0] rnd = 32'h2B21CAA5;

  initial forever #50 pclk = ~pclk;
  // Link clock offset so its edges never line up with the register clock.
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end

  i2c_status_mask i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk(link_clk), .link_ev(link_ev), .link_ev_valid(link_ev_valid),
    .link_ev_ready(link_ev_ready), .link_busy(link_busy), .link_tx_pending(link_tx_pending),
    .link_tx_byte(link_tx_byte), .rx_done_pulse(rx_done_pulse));

  i2c_bus_engine_model i_eng (.link_clk(link_clk), .link_ev_ready(link_ev_ready),
    .link_ev(link_ev), .link_ev_valid(link_ev_valid), .link_busy(link_busy));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; a read notes its expected result before the access phase.
  // The wait for pready has no limit of its own; the watchdog ends a hang.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [15:0] e, input logic err);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) expq.push_back({err, 16'h0, e});
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 16'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    apb(a, 1'b0, 32'h0, e, 1'b0);
  endtask

  // Send one event, then let the crossing into the register domain land.
  task automatic ev(input ev_kind_t k, input logic n, input logic [7:0] d);
    i_eng.send(k, n, d);
    repeat (4) @(posedge pclk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: every completed read is matched against the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cmp({pslverr, prdata}, expq.size() > 0 ? expq.pop_front() : 33'bx);
    end
    if (rx_done_pulse === 1'b1) pulses++;
  end

  // A hang is cut short well beyond the expected run of some 30 us.
  initial begin
    #2_000_000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STATUS, 16'h0000);
    rd(OFF_MASK, 16'h0000);
    apb(8'h18, 1'b0, 32'h0, 16'h0, 1'b1);
    wr(OFF_STATUS, 32'hFFFF);
    rd(OFF_STATUS, 16'hC7C0);
    wr(OFF_STATUS, 32'h0);
    rd(OFF_STATUS, 16'h0000);
    rnd = lfsr(rnd);
    wr(OFF_MASK, rnd | 32'h3FF);
    rd(OFF_MASK, 16'h03FF);
    wr(OFF_MASK, {rnd[31:10], 10'h001});
    rd(OFF_MASK, 16'h0001);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_OWN_ADDR, 32'h2A);
    ev(EV_START, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h0008);
    // Address 0x2B only matches because mask bit 0 excludes it from the compare.
    ev(EV_ADDR_BYTE, 1'b0, 8'h57);
    rd(OFF_STATUS, 16'h000E);
    rd(OFF_RX, 16'h0057);
    rd(OFF_STATUS, 16'h000C);
    ev(EV_DATA_BYTE, 1'b0, 8'h3C);
    rd(OFF_STATUS, 16'h002E);
    ev(EV_DATA_BYTE, 1'b0, 8'h99);
    rd(OFF_STATUS, 16'h006E);
    rd(OFF_RX, 16'h003C);
    wr(OFF_STATUS, 32'h0);
    rd(OFF_STATUS, 16'h002C);
    ev(EV_START, 1'b0, 8'h00);
    ev(EV_ADDR_BYTE, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h020A);
    rd(OFF_RX, 16'h0000);
    ev(EV_STOP, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h0010);
    // Upper mask bits do not count in seven-bit mode, so 0x2B must miss 0x2A.
    wr(OFF_MASK, 32'h380);
    rd(OFF_MASK, 16'h0380);
    ev(EV_START, 1'b0, 8'h00);
    ev(EV_ADDR_BYTE, 1'b0, 8'h56);
    rd(OFF_STATUS, 16'h0008);
    ev(EV_STOP, 1'b0, 8'h00);
    wr(OFF_TX, 32'hA5);
    rd(OFF_STATUS, 16'h0011);
    repeat (3) @(posedge pclk);
    cmp({24'h0, link_tx_pending, link_tx_byte}, 33'h1A5);
    wr(OFF_TX, 32'h5A);
    rd(OFF_STATUS, 16'h0091);
    ev(EV_MTX_BEGIN, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h4091);
    ev(EV_ACK_SLOT, 1'b1, 8'h00);
    rd(OFF_STATUS, 16'h8091);
    ev(EV_TX_DONE, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h8090);
    ev(EV_MTX_BEGIN, 1'b0, 8'h00);
    ev(EV_ACK_SLOT, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h0090);
    ev(EV_COLLISION, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h0490);
    ev(EV_START, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h0488);
    wr(OFF_STATUS, 32'h0);
    // Ten-bit address 0x2A5 arrives as 0xF4 then 0xA5.
    wr(OFF_CTRL, 32'h1);
    wr(OFF_OWN_ADDR, 32'h2A5);
    wr(OFF_MASK, 32'h0);
    ev(EV_ADDR_BYTE, 1'b0, 8'hF4);
    rd(OFF_STATUS, 16'h000A);
    rd(OFF_RX, 16'h00F4);
    ev(EV_ADDR_BYTE, 1'b0, 8'hA5);
    rd(OFF_STATUS, 16'h010A);
    rd(OFF_RX, 16'h00A5);
    ev(EV_STOP, 1'b0, 8'h00);
    rd(OFF_STATUS, 16'h0010);
    repeat (4) @(posedge pclk);
    // Five bytes reach the buffer; the overflowing byte is dropped without a pulse.
    cmp({1'b0, pulses}, 33'd5);
    stop_test();
  end
endmodule
